/* File: src/rpc_params.svh */
/*
  Constants of the regulator enable and power-good controller:
  register offsets, field positions, reset defaults and timing.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
// Contract
// - Reset loads defaults, opens the register port, then settles in standby.
// - Regulator enables are honoured only in standby or active state.
// - On bit 0 keeps regulator off; on bit 1 without pin-follow runs it.
// - On bit and pin-follow both set: regulator follows the sequencing pin.
// - Pin rising edge starts each regulator after its own rise delay.
// - Pin falling edge stops each regulator after its own fall delay.
// - Delays apply only to pin edges, never to register writes.
// - Buck below 0.35 V for 1 ms is disabled and flags a short.
// - Linear regulator below 0.3 V for 1 ms is disabled and flags short.
// - Buck reaching power-good sets its good flag unless rise-masked.
// - Linear regulator reaching power-good sets its good flag unless rise-masked.
// - Output turning invalid sets the good flag unless fall-masked.
// - Good state bit shows output validity registered one clock earlier.
// - Buck window bit picks undervoltage only or under plus overvoltage.
// - Linear window bit picks the linear regulator validity method.
// - A configuration bit connects the sequencing pin pulldown.
// - Interrupt output stays low while any flag is pending.
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH
`define RPC_ADDR_ENABLE 12'h000
`define RPC_ADDR_DELAY 12'h004
`define RPC_ADDR_VBUCK 12'h008
`define RPC_ADDR_VLIN 12'h00c
`define RPC_ADDR_CONFIG 12'h010
`define RPC_ADDR_MASK 12'h014
`define RPC_ADDR_FLAGS 12'h018
`define RPC_ADDR_STATUS 12'h01c
`define RPC_FOLLOW_LSB 8
`define RPC_FALL_LSB 16
`define RPC_GOOD_LSB 8
`define RPC_CFG_BUCK_WIN 0
`define RPC_CFG_LIN_WIN 1
`define RPC_CFG_PULLDOWN 2
`define RPC_DEF_ON 4'h0
`define RPC_DEF_FOLLOW 4'h0
`define RPC_DEF_DELAY 32'h0000_0000
`define RPC_DEF_VBUCK 16'h0000
`define RPC_DEF_VLIN 10'h000
`define RPC_DEF_CONFIG 3'h4
`define RPC_DEF_RISE_MASK 4'h0
`define RPC_DEF_FALL_MASK 4'h0
`define RPC_CLK_PERIOD_NS 10
`define RPC_SHORT_TIME_NS 1000000
`define RPC_DELAY_STEP_NS 1000000
`endif

/* File: src/rpc_pkg.sv */
/*
  Types shared by the regulator controller.
  Assumes the constants header is included by the design files.
*/
package rpc_pkg;
  typedef enum logic [1:0] {
    RPC_LOAD,
    RPC_STANDBY,
    RPC_ACTIVE
  } rpc_state_t;
endpackage : rpc_pkg

/* File: src/rpc_regulator_ctrl.sv */
/*
  Enable, sequencing, short-circuit and power-good logic for two buck
  converters (index 0,1) and two linear regulators (index 2,3).
  Assumes analog comparators deliver levels synchronous to clk and an
  APB master that holds each request until pready.
*/
`timescale 1ns/1ns
`include "rpc_params.svh"
module rpc_regulator_ctrl #(
  parameter int unsigned SHORT_CYCLES =
    (`RPC_SHORT_TIME_NS + `RPC_CLK_PERIOD_NS - 1) / `RPC_CLK_PERIOD_NS,
  parameter int unsigned DELAY_STEP_CYCLES =
    (`RPC_DELAY_STEP_NS + `RPC_CLK_PERIOD_NS - 1) / `RPC_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic seqPin,
  input wire logic [3:0] aboveShortLevel,
  input wire logic [3:0] aboveUnderLevel,
  input wire logic [3:0] belowOverLevel,
  output logic [3:0] regEnable,
  output logic [15:0] buckVoltageSetting,
  output logic [9:0] linregVoltageSetting,
  output logic seqPinPulldownOn,
  output logic irqOutN
);
  rpc_pkg::rpc_state_t state_q;
  logic [3:0] onBit_q;
  logic [3:0] pinFollow_q;
  logic [31:0] delay_q;
  logic [15:0] vbuck_q;
  logic [9:0] vlin_q;
  logic [2:0] config_q;
  logic [3:0] riseMask_q;
  logic [3:0] fallMask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [3:0] regEn_q;
  logic irqN_q;
  logic seqPrev_q;
  rpc_pkg::rpc_state_t state_d;
  wire hostOn = state_q != rpc_pkg::RPC_LOAD;
  wire access = psel && penable && hostOn;
  wire doWrite = access && pwrite && pready_q;
  wire [3:0] shortEvt;
  wire [3:0] shortFlag;
  wire [3:0] goodFlag;
  wire [3:0] goodState;
  wire pinRise = seqPin && !seqPrev_q;
  wire pinFall = !seqPin && seqPrev_q;
  wire runAllowed = state_q == rpc_pkg::RPC_STANDBY || state_q == rpc_pkg::RPC_ACTIVE;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = a == r;
  endfunction : hit

  wire mapped = hit(paddr, `RPC_ADDR_ENABLE) || hit(paddr, `RPC_ADDR_DELAY) ||
    hit(paddr, `RPC_ADDR_VBUCK) || hit(paddr, `RPC_ADDR_VLIN) ||
    hit(paddr, `RPC_ADDR_CONFIG) || hit(paddr, `RPC_ADDR_MASK) ||
    hit(paddr, `RPC_ADDR_FLAGS) || hit(paddr, `RPC_ADDR_STATUS);
  wire clearStrobe = doWrite && hit(paddr, `RPC_ADDR_FLAGS);
  wire [3:0] shortClr = clearStrobe ? pwdata[3:0] : 4'h0;
  wire [3:0] goodClr = clearStrobe ? pwdata[`RPC_GOOD_LSB+3:`RPC_GOOD_LSB] : 4'h0;

  wire [31:0] readMux =
    hit(paddr, `RPC_ADDR_ENABLE) ? {20'h0, pinFollow_q, 4'h0, onBit_q} :
    hit(paddr, `RPC_ADDR_DELAY) ? delay_q :
    hit(paddr, `RPC_ADDR_VBUCK) ? {16'h0, vbuck_q} :
    hit(paddr, `RPC_ADDR_VLIN) ? {19'h0, vlin_q[9:5], 3'h0, vlin_q[4:0]} :
    hit(paddr, `RPC_ADDR_CONFIG) ? {29'h0, config_q} :
    hit(paddr, `RPC_ADDR_MASK) ? {20'h0, fallMask_q, 4'h0, riseMask_q} :
    hit(paddr, `RPC_ADDR_FLAGS) ? {20'h0, goodFlag, 4'h0, shortFlag} :
    hit(paddr, `RPC_ADDR_STATUS) ? {22'h0, state_q, regEn_q, goodState} :
    32'h0;

  // Code 3 is never reached; should it appear, a fresh default load follows
  always_comb
  begin
    unique case (state_q)
      rpc_pkg::RPC_LOAD: state_d = rpc_pkg::RPC_STANDBY;
      rpc_pkg::RPC_STANDBY: state_d = (|regEn_q) ? rpc_pkg::RPC_ACTIVE : rpc_pkg::RPC_STANDBY;
      rpc_pkg::RPC_ACTIVE: state_d = (|regEn_q) ? rpc_pkg::RPC_ACTIVE : rpc_pkg::RPC_STANDBY;
      default: state_d = rpc_pkg::RPC_LOAD;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= access && !pready_q;
      pslverr_q <= access && !pready_q && !mapped;
      prdata_q <= (access && !pready_q && !pwrite) ? readMux : 32'h0;
    end
  end

  // Defaults are loaded one cycle after reset; the port stays deaf until then
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q <= rpc_pkg::RPC_LOAD;
      onBit_q <= 4'h0;
      pinFollow_q <= 4'h0;
      delay_q <= 32'h0;
      vbuck_q <= 16'h0;
      vlin_q <= 10'h0;
      config_q <= 3'h0;
      riseMask_q <= 4'h0;
      fallMask_q <= 4'h0;
    end
    else if (state_q == rpc_pkg::RPC_LOAD)
    begin
      onBit_q <= `RPC_DEF_ON;
      pinFollow_q <= `RPC_DEF_FOLLOW;
      delay_q <= `RPC_DEF_DELAY;
      vbuck_q <= `RPC_DEF_VBUCK;
      vlin_q <= `RPC_DEF_VLIN;
      config_q <= `RPC_DEF_CONFIG;
      riseMask_q <= `RPC_DEF_RISE_MASK;
      fallMask_q <= `RPC_DEF_FALL_MASK;
      state_q <= state_d;
    end
    else
    begin
      state_q <= state_d;
      if (doWrite && hit(paddr, `RPC_ADDR_ENABLE))
      begin
        pinFollow_q <= pwdata[`RPC_FOLLOW_LSB+3:`RPC_FOLLOW_LSB];
        onBit_q <= pwdata[3:0] & ~shortEvt;
      end
      else
        onBit_q <= onBit_q & ~shortEvt;
      if (doWrite && hit(paddr, `RPC_ADDR_DELAY))
        delay_q <= pwdata;
      if (doWrite && hit(paddr, `RPC_ADDR_VBUCK))
        vbuck_q <= pwdata[15:0];
      if (doWrite && hit(paddr, `RPC_ADDR_VLIN))
        vlin_q <= {pwdata[12:8], pwdata[4:0]};
      if (doWrite && hit(paddr, `RPC_ADDR_CONFIG))
        config_q <= pwdata[2:0];
      if (doWrite && hit(paddr, `RPC_ADDR_MASK))
      begin
        riseMask_q <= pwdata[3:0];
        fallMask_q <= pwdata[`RPC_FOLLOW_LSB+3:`RPC_FOLLOW_LSB];
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_reg
      logic pinView_q;
      logic pend_q;
      logic pendDir_q;
      logic [20:0] dlyCnt_q;
      logic [20:0] scCnt_q;
      logic good_q;
      logic shortFlag_q;
      logic goodFlag_q;
      logic run_q;
      wire [3:0] riseField = delay_q[4*i+3:4*i];
      wire [3:0] fallField = delay_q[`RPC_FALL_LSB+4*i+3:`RPC_FALL_LSB+4*i];
      wire [20:0] riseLoad = 21'(riseField * DELAY_STEP_CYCLES);
      wire [20:0] fallLoad = 21'(fallField * DELAY_STEP_CYCLES);
      // Window bit set: output must also stay below the overvoltage level
      wire winSel = (i < 2) ? config_q[`RPC_CFG_BUCK_WIN] : config_q[`RPC_CFG_LIN_WIN];
      // A disabled rail is never good, so switching it off can raise a fall flag
      wire goodNow = regEn_q[i] && aboveUnderLevel[i] && (!winSel || belowOverLevel[i]);
      wire want = runAllowed && onBit_q[i] && (!pinFollow_q[i] || pinView_q);
      assign shortEvt[i] = regEn_q[i] && !aboveShortLevel[i] &&
        scCnt_q == 21'(SHORT_CYCLES - 1);
      assign shortFlag[i] = shortFlag_q;
      assign goodFlag[i] = goodFlag_q;
      assign goodState[i] = good_q;

      // A new pin edge restarts the pending delay with the new direction, or cancels it when that direction's delay field is zero
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          pinView_q <= 1'b0;
          pend_q <= 1'b0;
          pendDir_q <= 1'b0;
          dlyCnt_q <= 21'h0;
        end
        else if (pinRise && riseField == 4'h0)
        begin
          pinView_q <= 1'b1;
          pend_q <= 1'b0;
        end
        else if (pinFall && fallField == 4'h0)
        begin
          pinView_q <= 1'b0;
          pend_q <= 1'b0;
        end
        else if (pinRise || pinFall)
        begin
          pend_q <= 1'b1;
          pendDir_q <= pinRise;
          dlyCnt_q <= pinRise ? riseLoad : fallLoad;
        end
        else if (pend_q)
        begin
          dlyCnt_q <= dlyCnt_q - 21'h1;
          if (dlyCnt_q == 21'h1)
          begin
            pend_q <= 1'b0;
            pinView_q <= pendDir_q;
          end
        end
      end

      // The low-output timer covers both a failed start and a later collapse
      always_ff @(posedge clk)
      begin
        if (!rstn || !regEn_q[i] || aboveShortLevel[i])
          scCnt_q <= 21'h0;
        else if (!shortEvt[i])
          scCnt_q <= scCnt_q + 21'h1;
      end

      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          good_q <= 1'b0;
          shortFlag_q <= 1'b0;
          goodFlag_q <= 1'b0;
        end
        else
        begin
          good_q <= goodNow;
          shortFlag_q <= shortEvt[i] || (shortFlag_q && !shortClr[i]);
          goodFlag_q <= (goodNow && !good_q && !riseMask_q[i]) ||
            (!goodNow && good_q && !fallMask_q[i]) ||
            (goodFlag_q && !goodClr[i]);
        end
      end

      // Register writes act here at once; only pin edges pass the delay counter
      always_ff @(posedge clk)
      begin
        if (!rstn)
          run_q <= 1'b0;
        else
          run_q <= want && !shortEvt[i];
      end
      assign regEn_q[i] = run_q;
    end
  endgenerate

  logic [15:0] vbuckOut_q;
  logic [9:0] vlinOut_q;
  logic pullOut_q;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      seqPrev_q <= 1'b0;
      irqN_q <= 1'b1;
      vbuckOut_q <= 16'h0;
      vlinOut_q <= 10'h0;
      pullOut_q <= 1'b0;
    end
    else
    begin
      seqPrev_q <= seqPin;
      // Masks gate the good flags themselves and short flags have no mask, so the output needs no mask of its own
      irqN_q <= !(|shortFlag || |goodFlag);
      vbuckOut_q <= vbuck_q;
      vlinOut_q <= vlin_q;
      pullOut_q <= config_q[`RPC_CFG_PULLDOWN];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign regEnable = regEn_q;
  assign buckVoltageSetting = vbuckOut_q;
  assign linregVoltageSetting = vlinOut_q;
  assign seqPinPulldownOn = pullOut_q;
  assign irqOutN = irqN_q;
endmodule : rpc_regulator_ctrl

/* File: tb/rpc_rail_model.sv */
/* Rail comparator model; assumes regEnable from the controller, faults from the bench. */
`timescale 1ns/1ns
module rpc_rail_model (
  input wire logic clk,
  input wire logic [3:0] regEnable,
  input wire logic [3:0] shortCmd,
  input wire logic [3:0] overCmd,
  output logic [3:0] aboveShortLevel,
  output logic [3:0] aboveUnderLevel,
  output logic [3:0] belowOverLevel
);
  // A rail rises one cycle after enable; a shorted rail never rises
  logic [3:0] railUp_q = 4'h0;
  always_ff @(posedge clk)
    railUp_q <= regEnable & ~shortCmd;
  assign aboveShortLevel = railUp_q;
  assign aboveUnderLevel = railUp_q;
  assign belowOverLevel = ~overCmd;
endmodule : rpc_rail_model

/* File: tb/rpc_ctrl_asserts.sv */
/* Port checker bound to rpc_regulator_ctrl; one clock, rstn synchronous active low. */
`timescale 1ns/1ns
module rpc_ctrl_asserts #(
  parameter int unsigned SHORT_CYCLES = 20,
  parameter int unsigned DELAY_STEP_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [3:0] aboveShortLevel,
  input wire logic [3:0] regEnable,
  input wire logic seqPinPulldownOn,
  input wire logic irqOutN
);
  // One cycle of slack: the short timer drops a registered enable
  localparam int unsigned LIM = SHORT_CYCLES + 1;
  logic wr;
  logic clr;
  logic [31:0] wData_q;
  logic [3:0] onBits_q;
  int unsigned lowRun_q [4];
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  assign wr = psel && penable && pready && pwrite;
  assign clr = wr && paddr == 12'h018;
  always_ff @(posedge clk)
  begin
    if (wr)
      wData_q <= pwdata;
    if (!rstn)
      onBits_q <= 4'h0;
    else if (wr && paddr == 12'h000)
      onBits_q <= pwdata[3:0];
    for (int i = 0; i < 4; i++)
      lowRun_q[i] <= (rstn && regEnable[i] && !aboveShortLevel[i]) ? lowRun_q[i] + 1 : 0;
  end
  sequence settle;
    irqOutN ##1 irqOutN ##[0:2] seqPinPulldownOn;
  endsequence
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  chk_ready_wait: assert property (psel && $rose(penable) |=> pready) else $error("late answer");
  chk_reset_dflt: assert property ($rose(rstn) |-> settle) else $error("bad defaults");
  chk_irq_clear: assert property ($rose(irqOutN) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
    else $error("irq released early");
  chk_on_gate: assert property ((regEnable & ~onBits_q & ~$past(onBits_q) & ~$past(onBits_q, 2)) == 4'h0)
    else $error("enable without on bit");
  chk_on_write: assert property (wr && paddr == 12'h000 && pwdata[11:8] == 4'h0 |=> ##[0:1]
    regEnable == wData_q[3:0]) else $error("enable write delayed");
  chk_pull_cfg: assert property (wr && paddr == 12'h010 |=> ##[0:1] seqPinPulldownOn == wData_q[2])
    else $error("pulldown not set");
  chk_short_off: assert property (lowRun_q[0] <= LIM && lowRun_q[1] <= LIM &&
    lowRun_q[2] <= LIM && lowRun_q[3] <= LIM) else $error("short not stopped");
endmodule : rpc_ctrl_asserts
bind rpc_regulator_ctrl rpc_ctrl_asserts #(.SHORT_CYCLES(SHORT_CYCLES), .DELAY_STEP_CYCLES(DELAY_STEP_CYCLES))
  u_rpc_ctrl_asserts (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .aboveShortLevel,
  .regEnable, .seqPinPulldownOn, .irqOutN);

/* File: tb/tb_rpc_regulator_ctrl.sv */
/* Bench for rpc_regulator_ctrl over APB; assumes the rail model and bound checker. */
`timescale 1ns/1ns
module tb_rpc_regulator_ctrl;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic seqPin = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] shortCmd = 4'h0;
  logic [3:0] overCmd = 4'h0;
  logic [31:0] prdata, rd;
  logic [3:0] sLvl, uLvl, oLvl, regEnable;
  logic [15:0] vBuck;
  logic [9:0] vLin;
  logic pready, pslverr, pdOn, irqN, err;
  int n_fail = 0;
  int checked = 0;
  initial forever #5 clk = ~clk;
  rpc_regulator_ctrl #(.SHORT_CYCLES(20), .DELAY_STEP_CYCLES(10)) u_rpc_regulator_ctrl (.clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .seqPin, .aboveShortLevel(sLvl),
    .aboveUnderLevel(uLvl), .belowOverLevel(oLvl), .regEnable, .buckVoltageSetting(vBuck),
    .linregVoltageSetting(vLin), .seqPinPulldownOn(pdOn), .irqOutN(irqN));
  rpc_rail_model u_rpc_rail_model (.clk, .regEnable, .shortCmd, .overCmd, .aboveShortLevel(sLvl),
    .aboveUnderLevel(uLvl), .belowOverLevel(oLvl));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : xfer
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : put
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    cmp(rd, e);
  endtask : rchk
  // Pin-driven enables: cycles counted from the task call (pin change, or the previous rail's switch), one cycle of slack either way
  task automatic span(input int i, input logic v, input int e);
    int n;
    n = 0;
    while (regEnable[i] !== v && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    cmp({31'h0, n >= e - 1 && n <= e + 1}, 32'h1);
  endtask : span
  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    // Host wait after power-up shortened to keep the run brief
    repeat (3) @(posedge clk);
    rchk(12'h010, 32'h4);
    cmp({31'h0, pdOn}, 32'h1);
    rchk(12'h01c, 32'h100);
    xfer(1'h0, 12'h020, 32'h0);
    cmp({31'h0, err}, 32'h1);
    put(12'h008, 32'h1234_a55a);
    put(12'h00c, 32'h0000_fa15);
    rchk(12'h008, 32'h0000_a55a);
    rchk(12'h00c, 32'h0000_1a15);
    cmp({16'h0, vBuck}, 32'h0000_a55a);
    cmp({22'h0, vLin}, 32'h0000_0355);
    put(12'h000, 32'h1);
    repeat (4) @(posedge clk);
    rchk(12'h01c, 32'h211);
    rchk(12'h018, 32'h100);
    cmp({31'h0, irqN}, 32'h0);
    put(12'h018, 32'h100);
    repeat (2) @(posedge clk);
    cmp({31'h0, irqN}, 32'h1);
    put(12'h000, 32'h0);
    repeat (4) @(posedge clk);
    rchk(12'h018, 32'h100);
    put(12'h018, 32'h100);
    put(12'h014, 32'h4);
    put(12'h000, 32'h4);
    repeat (4) @(posedge clk);
    rchk(12'h018, 32'h0);
    put(12'h014, 32'h400);
    put(12'h000, 32'h0);
    repeat (4) @(posedge clk);
    rchk(12'h018, 32'h0);
    put(12'h014, 32'h0);
    put(12'h004, 32'h0010_0020);
    put(12'h000, 32'h303);
    rchk(12'h01c, 32'h100);
    seqPin <= 1'h1;
    span(0, 1'h1, 3);
    span(1, 1'h1, 20);
    seqPin <= 1'h0;
    span(0, 1'h0, 3);
    span(1, 1'h0, 10);
    put(12'h018, 32'hf0f);
    for (int i = 0; i < 4; i++)
    begin
      shortCmd <= 4'h1 << i;
      put(12'h000, 32'h1 << i);
      repeat (25) @(posedge clk);
      rchk(12'h018, 32'h1 << i);
      rchk(12'h000, 32'h0);
      put(12'h018, 32'hf);
    end
    shortCmd <= 4'h0;
    overCmd <= 4'h5;
    put(12'h010, 32'h7);
    put(12'h000, 32'h5);
    repeat (4) @(posedge clk);
    rchk(12'h01c, 32'h250);
    put(12'h010, 32'h0);
    repeat (4) @(posedge clk);
    rchk(12'h01c, 32'h255);
    cmp({31'h0, pdOn}, 32'h0);
    results();
  end
  initial
  begin
    #100000;
    n_fail++;
    results();
  end
endmodule : tb_rpc_regulator_ctrl
